// ===== docs_pkg.sv
package docs_pkg;

    // serial frame layout
    localparam int          FRAME_BITS    = 24;
    localparam int          RD_FLAG_POS   = 23;
    localparam int          FAULT_POS     = 21;
    localparam int          ADDR_HI       = 20;
    localparam int          ADDR_LO       = 16;
    localparam logic [5:0]  FRAME_BITS_C  = 6'h18;

    // converter output configuration register
    localparam logic [4:0]  CFG_ADDR      = 5'h06;
    localparam logic [23:0] CFG_RESET     = 24'h060C00;
    localparam logic [15:0] CFG_RESET_DAT = CFG_RESET[15:0];

    // field positions inside the data half of the word
    localparam int          INC_HI        = 15;
    localparam int          INC_LO        = 13;
    localparam int          RATE_HI       = 12;
    localparam int          RATE_LO       = 9;
    localparam int          SLEW_ON_POS   = 8;
    localparam int          EXT_RES_POS   = 7;
    localparam int          OUT_EN_POS    = 6;
    localparam int          BUF_PWR_POS   = 5;
    localparam int          OVRNG_POS     = 4;
    localparam int          RANGE_HI      = 3;
    localparam int          RANGE_LO      = 0;

    // range codes accepted by a write
    function automatic logic range_valid(input logic [3:0] code);
        return (code <= 4'h3) || ((code >= 4'h8) && (code <= 4'hD));
    endfunction

    // output change per slew tick, in lsb
    function automatic logic [15:0] step_lsb(input logic [2:0] sel);
        case (sel)
            3'h0:    return 16'h0004;
            3'h1:    return 16'h000C;
            3'h2:    return 16'h0040;
            3'h3:    return 16'h0080;
            3'h4:    return 16'h0100;
            3'h5:    return 16'h0200;
            3'h6:    return 16'h0400;
            default: return 16'h0800;
        endcase
    endfunction

    // slew tick rate in hz
    function automatic int rate_hz(input logic [3:0] sel);
        case (sel)
            4'h0:    return 240000;
            4'h1:    return 200000;
            4'h2:    return 150000;
            4'h3:    return 128000;
            4'h4:    return 64000;
            4'h5:    return 32000;
            4'h6:    return 16000;
            4'h7:    return 8000;
            4'h8:    return 4000;
            4'h9:    return 2000;
            4'hA:    return 1000;
            4'hB:    return 512;
            4'hC:    return 256;
            4'hD:    return 128;
            4'hE:    return 64;
            default: return 16;
        endcase
    endfunction

endpackage

// ===== docs_tick_gen.sv
`timescale 1ns/10ps
// one-cycle tick at the selected slew update rate
module docs_tick_gen #(
    parameter int CLK_HZ = 125000000
) (
    input  wire logic       i_sys_clk,
    input  wire logic       i_rst_n,
    input  wire logic       i_enable,
    input  wire logic [3:0] i_rate_sel,
    output logic            o_tick
);

    // the fastest tick rate needs at least one clock per tick
    if (CLK_HZ < 240000) begin : g_bad_clk
        $error("docs_tick_gen: CLK_HZ too small");
    end

    logic [31:0] count;
    logic [31:0] next_count;
    logic        next_tick;
    logic [31:0] period;

    // cycles per tick, never below one
    always_comb begin
        period = 32'(CLK_HZ / docs_pkg::rate_hz(i_rate_sel));
        if (period == 32'h0) period = 32'h1;
        next_count = count;
        next_tick  = 1'b0;
        if (!i_enable) begin
            next_count = 32'h0;
        end else if (count + 32'h1 >= period) begin
            next_count = 32'h0;
            next_tick  = 1'b1;
        end else begin
            next_count = count + 32'h1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            count  <= 32'h0;
            o_tick <= 1'b0;
        end else begin
            count  <= next_count;
            o_tick <= next_tick;
        end
    end

endmodule

// ===== docs_config_slew.sv
`timescale 1ns/10ps
// What this block does
// - readback bit 21 shows the inverted fault pin level; writes ignored
// - readback bits 20 to 16 carry the register address, read only
// - register sits at address 0x06, resets to 0x060C00
// - bits 15 to 13 choose the output change per slew tick
// - bits 12 to 9 choose the slew tick rate, 240 kHz down to 16 Hz
// - with slew on, code moves one step per tick toward the target
// - bit 8 turns slew limiting on, off after reset
// - bit 7 picks the external current setting resistor, internal by default
// - bit 6 enables the output terminal driver, off by default
// - bit 5 powers converter core and amplifiers without the output driver
// - bit 4 extends the voltage ranges by twenty percent
// - range codes 0000 to 0011 are voltage ranges
// - range codes 1000 to 1101 are current ranges
// - a write with any other range code is dropped whole
// - a range change starts a calibration refresh; pending flag holds until done
module docs_config_slew #(
    parameter int CLK_HZ = 125000000,
    parameter int CODE_W = 16
) (
    input  wire logic              i_sys_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_sclk,
    input  wire logic              i_sync_n,
    input  wire logic              i_sdi,
    input  wire logic              i_fault_n,
    input  wire logic [CODE_W-1:0] i_target_code,
    input  wire logic              i_target_valid,
    input  wire logic              i_refresh_done,
    output logic                   o_sdo,
    output logic                   o_sdo_oe,
    output logic [3:0]             o_range,
    output logic                   o_overrange_on,
    output logic                   o_buffer_power_on,
    output logic                   o_output_enable,
    output logic                   o_external_resistor_select,
    output logic                   o_refresh_start,
    output logic                   o_calibration_refresh_pending,
    output logic [CODE_W-1:0]      o_output_code
);

    if (CODE_W != 16) begin : g_bad_width
        $error("docs_config_slew: CODE_W must be 16");
    end

    // two-flop synchronisers for the pins, plus an edge-history flop each for sclk and sync
    logic sclk_s1, sclk_s2, sclk_d;
    logic sync_s1, sync_s2, sync_d;
    logic sdi_s1, sdi_s2;
    logic fault_s1, fault_s2;

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            sclk_s1  <= 1'b0;
            sclk_s2  <= 1'b0;
            sclk_d   <= 1'b0;
            sync_s1  <= 1'b1;
            sync_s2  <= 1'b1;
            sync_d   <= 1'b1;
            sdi_s1   <= 1'b0;
            sdi_s2   <= 1'b0;
            fault_s1 <= 1'b1;
            fault_s2 <= 1'b1;
        end else begin
            sclk_s1  <= i_sclk;
            sclk_s2  <= sclk_s1;
            sclk_d   <= sclk_s2;
            sync_s1  <= i_sync_n;
            sync_s2  <= sync_s1;
            sync_d   <= sync_s2;
            sdi_s1   <= i_sdi;
            sdi_s2   <= sdi_s1;
            fault_s1 <= i_fault_n;
            fault_s2 <= fault_s1;
        end
    end

    logic sclk_rise, sclk_fall, frame_start, frame_end;
    assign sclk_rise   = sclk_s2 & ~sclk_d & ~sync_s2;
    assign sclk_fall   = ~sclk_s2 & sclk_d & ~sync_s2;
    assign frame_start = ~sync_s2 & sync_d;
    assign frame_end   = sync_s2 & ~sync_d;

    // serial shifter state
    logic [23:0] shift_in, next_shift_in;
    logic [23:0] shift_out, next_shift_out;
    logic [5:0]  bit_cnt, next_bit_cnt;
    logic [4:0]  rb_addr, next_rb_addr;
    logic        next_sdo, next_sdo_oe;
    logic        commit;
    logic [23:0] rb_word;
    logic [15:0] cfg, next_cfg;

    // readback word for the address asked for in the last read frame
    always_comb begin
        rb_word = 24'h0;
        rb_word[docs_pkg::FAULT_POS] = ~fault_s2;
        rb_word[docs_pkg::ADDR_HI:docs_pkg::ADDR_LO] = rb_addr;
        if (rb_addr == docs_pkg::CFG_ADDR) rb_word[15:0] = cfg;
    end

    // shift in on rising sclk, shift out on falling sclk, frame on sync
    always_comb begin
        next_shift_in  = shift_in;
        next_shift_out = shift_out;
        next_bit_cnt   = bit_cnt;
        next_sdo       = o_sdo;
        next_sdo_oe    = o_sdo_oe;
        commit         = 1'b0;
        if (frame_start) begin
            next_shift_out = rb_word;
            next_sdo       = rb_word[23];
            next_sdo_oe    = 1'b1;
            next_bit_cnt   = 6'h0;
        end else if (frame_end) begin
            next_sdo_oe = 1'b0;
            commit      = (bit_cnt == docs_pkg::FRAME_BITS_C);
        end else if (sclk_rise) begin
            next_shift_in = {shift_in[22:0], sdi_s2};
            if (bit_cnt != 6'h3F) next_bit_cnt = bit_cnt + 6'h1;
        end else if (sclk_fall) begin
            next_shift_out = {shift_out[22:0], 1'b0};
            next_sdo       = shift_out[22];
        end
    end

    // configuration register and refresh flag
    logic        next_refresh_start, next_pending;
    logic        wr_cfg, wr_ok;

    always_comb begin
        next_cfg           = cfg;
        next_rb_addr       = rb_addr;
        next_refresh_start = 1'b0;
        wr_cfg = commit && !shift_in[docs_pkg::RD_FLAG_POS]
                 && (shift_in[docs_pkg::ADDR_HI:docs_pkg::ADDR_LO] == docs_pkg::CFG_ADDR);
        wr_ok  = docs_pkg::range_valid(shift_in[3:0]);
        if (commit && shift_in[docs_pkg::RD_FLAG_POS]) begin
            next_rb_addr = shift_in[docs_pkg::ADDR_HI:docs_pkg::ADDR_LO];
        end
        if (wr_cfg && wr_ok) begin
            next_cfg = shift_in[15:0];
            if (shift_in[3:0] != cfg[3:0]) next_refresh_start = 1'b1;
        end
        // a new start wins over a completion in the same cycle
        next_pending = next_refresh_start | (o_calibration_refresh_pending & ~i_refresh_done);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            shift_in  <= 24'h0;
            shift_out <= 24'h0;
            bit_cnt   <= 6'h0;
            rb_addr   <= 5'h0;
            o_sdo     <= 1'b0;
            o_sdo_oe  <= 1'b0;
            cfg       <= docs_pkg::CFG_RESET_DAT;
            o_refresh_start               <= 1'b0;
            o_calibration_refresh_pending <= 1'b0;
        end else begin
            shift_in  <= next_shift_in;
            shift_out <= next_shift_out;
            bit_cnt   <= next_bit_cnt;
            rb_addr   <= next_rb_addr;
            o_sdo     <= next_sdo;
            o_sdo_oe  <= next_sdo_oe;
            cfg       <= next_cfg;
            o_refresh_start               <= next_refresh_start;
            o_calibration_refresh_pending <= next_pending;
        end
    end

    // field outputs straight from the register flops
    assign o_range                    = cfg[docs_pkg::RANGE_HI:docs_pkg::RANGE_LO];
    assign o_overrange_on             = cfg[docs_pkg::OVRNG_POS];
    assign o_buffer_power_on          = cfg[docs_pkg::BUF_PWR_POS];
    assign o_output_enable            = cfg[docs_pkg::OUT_EN_POS];
    assign o_external_resistor_select = cfg[docs_pkg::EXT_RES_POS];

    logic slew_on;
    logic tick;
    assign slew_on = cfg[docs_pkg::SLEW_ON_POS];

    docs_tick_gen #(
        .CLK_HZ (CLK_HZ)
    ) u_tick (
        .i_sys_clk  (i_sys_clk),
        .i_rst_n    (i_rst_n),
        .i_enable   (slew_on),
        .i_rate_sel (cfg[docs_pkg::RATE_HI:docs_pkg::RATE_LO]),
        .o_tick     (tick)
    );

    // target capture and slew limited output code
    logic [15:0] target, next_target, next_code, step, gap;

    always_comb begin
        next_target = i_target_valid ? i_target_code : target;
        step        = docs_pkg::step_lsb(cfg[docs_pkg::INC_HI:docs_pkg::INC_LO]);
        gap         = (target > o_output_code) ? target - o_output_code : o_output_code - target;
        next_code   = o_output_code;
        if (!slew_on) begin
            next_code = target;
        end else if (tick && gap != 16'h0) begin
            if (gap <= step) next_code = target;
            else if (target > o_output_code) next_code = o_output_code + step;
            else next_code = o_output_code - step;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            target        <= 16'h0;
            o_output_code <= 16'h0;
        end else begin
            target        <= next_target;
            o_output_code <= next_code;
        end
    end

    property p_reset_value;
        @(posedge i_sys_clk) !i_rst_n |=> (cfg == docs_pkg::CFG_RESET_DAT) && !o_calibration_refresh_pending;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("config not at reset value");

    property p_refresh_set;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
            (wr_cfg && wr_ok && shift_in[3:0] != cfg[3:0]) |=> o_refresh_start && o_calibration_refresh_pending;
    endproperty
    a_refresh_set: assert property (p_refresh_set) else $error("range change did not start refresh");

    property p_pending_hold;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
            (o_calibration_refresh_pending && !i_refresh_done) |=> o_calibration_refresh_pending;
    endproperty
    a_pending_hold: assert property (p_pending_hold) else $error("pending flag dropped early");

    property p_bad_range;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
            (wr_cfg && !wr_ok) |=> $stable(cfg) && !o_refresh_start;
    endproperty
    a_bad_range: assert property (p_bad_range) else $error("invalid range write took effect");

    property p_good_write;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
            (wr_cfg && wr_ok) |=> cfg == $past(shift_in[15:0]);
    endproperty
    a_good_write: assert property (p_good_write) else $error("valid write not stored");

    property p_direct;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
            (!slew_on && !$past(slew_on)) ##1 !slew_on |-> o_output_code == $past(target);
    endproperty
    a_direct: assert property (p_direct) else $error("slew off did not apply target at once");

    property p_step_up;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
            (slew_on && tick && target > o_output_code && gap > step) |=> o_output_code == $past(o_output_code) + $past(step);
    endproperty
    a_step_up: assert property (p_step_up) else $error("slew step size wrong");

    property p_no_overshoot;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
            (slew_on && tick && gap <= step) |=> o_output_code == $past(target);
    endproperty
    a_no_overshoot: assert property (p_no_overshoot) else $error("final slew step not clamped");

    property p_hold_between;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
            (slew_on && !tick) |=> o_output_code == $past(o_output_code);
    endproperty
    a_hold_between: assert property (p_hold_between) else $error("code moved without a tick");

    property p_fault_bit;
        @(posedge i_sys_clk) disable iff (!i_rst_n)
            frame_start |=> o_sdo_oe && shift_out[docs_pkg::FAULT_POS] == !$past(fault_s2)
                            && shift_out[20:16] == $past(rb_addr);
    endproperty
    a_fault_bit: assert property (p_fault_bit) else $error("readback fault or address field wrong");

endmodule

// ===== docs_spi_host.sv
`timescale 1ns/10ps
// serial host model: frames msb first, clock idles low between frames
module docs_spi_host (
    output logic           o_sclk,
    output logic           o_sync_n,
    output logic           o_sdi,
    input  wire logic      i_sdo,
    input  wire logic      i_sdo_oe
);
    // idle levels before the first frame
    initial begin
        o_sclk = 1'b0;
        o_sync_n = 1'b1;
        o_sdi = 1'b0;
    end

    // one frame of n bits; a bit read while sdo is not driven comes back unknown
    task automatic xfer(input logic [23:0] w, input int n, output logic [23:0] r);
        r = 24'h000000;
        o_sync_n = 1'b0;
        #100;
        for (int i = 23; i > 23 - n; i--) begin
            o_sdi = w[i];
            #62.5;
            o_sclk = 1'b1;
            r[i] = i_sdo_oe ? i_sdo : 1'bx;
            #62.5;
            o_sclk = 1'b0;
        end
        #100;
        o_sync_n = 1'b1;
        o_sdi = ~o_sdi;  // released line shows no stale value
        #200;            // gap lets the device commit the frame
    endtask
endmodule

// ===== docs_config_slew_tb.sv
`timescale 1ns/10ps
module docs_config_slew_tb;
    localparam int CLK_HZ = 2400000;  // rate code 0 ticks every 10 cycles
    logic        i_sys_clk = 1'b0;
    logic        i_rst_n = 1'b0;
    logic        i_fault_n = 1'b1;
    logic [15:0] i_target_code = 16'h0000;
    logic        i_target_valid = 1'b0;
    logic        i_refresh_done = 1'b0;
    logic        sclk, sync_n, sdi, o_sdo, o_sdo_oe, o_overrange_on, o_buffer_power_on;
    logic        o_output_enable, o_external_resistor_select, o_refresh_start, o_calibration_refresh_pending;
    logic [3:0]  o_range;
    logic [15:0] o_output_code;
    logic [15:0] cfg = 16'h0C00;
    logic [15:0] cur = 16'h0000;
    logic [23:0] rr;
    logic [2:0]  sels [8] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    logic [3:0]  rates [8] = '{4'h0, 4'h1, 4'h0, 4'h6, 4'h0, 4'h1, 4'h0, 4'h0};
    // cycles per tick at CLK_HZ for the rate codes above
    logic [7:0]  ticks [8] = '{8'h0A, 8'h0C, 8'h0A, 8'h96, 8'h0A, 8'h0C, 8'h0A, 8'h0A};
    logic [15:0] steps [8] = '{16'h0004, 16'h000C, 16'h0040, 16'h0080, 16'h0100, 16'h0200, 16'h0400, 16'h0800};
    logic [15:0] tgts [8] = '{16'h1250, 16'h1200, 16'h1300, 16'h1100, 16'h1500, 16'h0F00, 16'h2000, 16'h0000};
    int          starts = 0;
    int          fails = 0;
    int          compares = 0;
    int          rcnt = 0;

    always #4 i_sys_clk = ~i_sys_clk;

    docs_config_slew #(.CLK_HZ(CLK_HZ)) u_dut (
        .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_sync_n(sync_n), .i_sdi(sdi),
        .i_fault_n(i_fault_n), .i_target_code(i_target_code), .i_target_valid(i_target_valid),
        .i_refresh_done(i_refresh_done), .o_sdo(o_sdo), .o_sdo_oe(o_sdo_oe), .o_range(o_range),
        .o_overrange_on(o_overrange_on), .o_buffer_power_on(o_buffer_power_on),
        .o_output_enable(o_output_enable), .o_external_resistor_select(o_external_resistor_select),
        .o_refresh_start(o_refresh_start), .o_calibration_refresh_pending(o_calibration_refresh_pending),
        .o_output_code(o_output_code)
    );

    docs_spi_host u_host (
        .o_sclk(sclk), .o_sync_n(sync_n), .o_sdi(sdi), .i_sdo(o_sdo), .i_sdo_oe(o_sdo_oe)
    );

    // refresh engine stand-in: done pulse 100 cycles after each start
    always @(negedge i_sys_clk) begin
        i_refresh_done <= (rcnt == 1);
        rcnt <= o_refresh_start ? 100 : (rcnt > 0 ? rcnt - 1 : 0);
        starts <= starts + int'(o_refresh_start);
    end

    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read request frame, answer comes in the following frame
    task automatic rd(input logic [4:0] a, input logic [15:0] d);
        logic [23:0] r;
        u_host.xfer({3'h4, a, 16'h0000}, 24, r);
        u_host.xfer({3'h4, a, 16'h0000}, 24, r);
        cmp(r, {2'h0, ~i_fault_n, a, d});
    endtask

    // write the register, check fields and refresh, wait out refresh, read back
    task automatic wr(input logic [15:0] d);
        logic [23:0] r;
        logic        ok;
        logic        pend;
        int          k;
        int          s0;
        ok = (d[3:0] <= 4'h3) || (d[3:0] >= 4'h8 && d[3:0] <= 4'hD);
        pend = ok && (d[3:0] != cfg[3:0]);
        if (ok) begin
            cfg = d;
        end
        s0 = starts;
        u_host.xfer({3'h0, docs_pkg::CFG_ADDR, d}, 24, r);
        @(negedge i_sys_clk);
        cmp(24'(o_calibration_refresh_pending), 24'(pend));
        cmp({16'h0000, o_range, o_overrange_on, o_buffer_power_on, o_output_enable, o_external_resistor_select},
            {16'h0000, cfg[3:0], cfg[4], cfg[5], cfg[6], cfg[7]});
        k = 0;
        while (o_calibration_refresh_pending !== 1'b0 && k < 400) begin
            @(negedge i_sys_clk);
            k++;
        end
        cmp(24'(o_calibration_refresh_pending), 24'h000000);
        cmp(24'(starts - s0), 24'(pend));
        rd(docs_pkg::CFG_ADDR, cfg);
    endtask

    // new target; every change must be one exact step or the final clamp to target, one tick apart
    task automatic slew(input logic [15:0] t, input logic [15:0] st, input logic [7:0] g);
        logic [15:0] e;
        int          gap;
        int          n;
        gap = 0;
        n = 0;
        @(negedge i_sys_clk);
        i_target_code = t;
        i_target_valid = 1'b1;
        @(negedge i_sys_clk);
        i_target_valid = 1'b0;
        while (cur !== t && gap < 300) begin
            @(negedge i_sys_clk);
            gap++;
            if (o_output_code !== cur) begin
                if (t > cur) begin
                    e = (t - cur > st) ? cur + st : t;
                end else begin
                    e = (cur - t > st) ? cur - st : t;
                end
                cmp({8'h00, o_output_code}, {8'h00, e});
                if (n > 0) begin
                    cmp(24'(gap), 24'(g));
                end
                cur = e;
                n++;
                gap = 0;
            end
        end
        repeat (15) @(negedge i_sys_clk);
        cmp({8'h00, o_output_code}, {8'h00, t});
    endtask

    task automatic summarize();
        $display("compares=%0d fails=%0d", compares, fails);
        if (fails == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // watchdog against a hung handshake
    initial begin
        #700000;
        fails++;
        summarize();
    end

    // main sequence
    initial begin
        repeat (10) @(negedge i_sys_clk);
        i_rst_n = 1'b1;
        repeat (3) @(negedge i_sys_clk);
        cmp({14'h0000, o_range, o_overrange_on, o_buffer_power_on, o_output_enable, o_external_resistor_select,
             o_refresh_start, o_calibration_refresh_pending}, 24'h000000);
        cmp({8'h00, o_output_code}, 24'h000000);
        rd(docs_pkg::CFG_ADDR, 16'h0C00);
        rd(5'h05, 16'h0000);
        wr(16'h0030);
        #201000;
        wr(16'h00F9);
        for (int c = 0; c < 16; c++) begin
            wr({12'h000, 4'(c)});
        end
        u_host.xfer({3'h0, docs_pkg::CFG_ADDR, 16'h0003}, 23, rr);
        rd(docs_pkg::CFG_ADDR, cfg);
        u_host.xfer({3'h0, 5'h05, 16'h0003}, 24, rr);
        rd(docs_pkg::CFG_ADDR, cfg);
        @(negedge i_sys_clk);
        i_fault_n = 1'b0;
        repeat (5) @(negedge i_sys_clk);
        rd(docs_pkg::CFG_ADDR, cfg);
        slew(16'h1234, 16'hFFFF, 8'h00);
        // every step code, with three different tick rates
        for (int i = 0; i < 8; i++) begin
            wr({sels[i], rates[i], 9'h10D});
            slew(tgts[i], steps[i], ticks[i]);
        end
        summarize();
    end
endmodule
